/* rtl/nscs_params.svh */
// Constants for the nibble sample clock select block
`ifndef NSCS_PARAMS_SVH
`define NSCS_PARAMS_SVH
`define NSCS_OFS_CFG 4'h0
`define NSCS_OFS_CTRL 4'h4
`define NSCS_OFS_STATUS 4'h8
`define NSCS_ADDR_W 4
`define NSCS_CFG_RST 8'h00
`define NSCS_CTRL_RST 1'h1
`define NSCS_RESP_OKAY 2'h0
`define NSCS_RESP_SLVERR 2'h2
`define NSCS_LANES 7
`define NSCS_GATE_W 4
`define NSCS_KEEP_A 1
`define NSCS_KEEP_B 6
`endif

/* rtl/nscs_pkg.sv */
// Types shared by the nibble sample clock select block
`default_nettype none
package nscs_pkg;
  // Configuration word, bit 0 is borrow_pos_read_clock
  typedef struct packed {
    logic tx_gate_en;
    logic invert_lane0;
    logic neg_shift90;
    logic pos_shift90;
    logic src_ref;
    logic serial_mode;
    logic borrow_neg_read_clock;
    logic borrow_pos_read_clock;
  } nscs_cfg_s;
endpackage : nscs_pkg
`default_nettype wire

/* rtl/nscs_tx_gate.sv */
// Per-lane transmit clock gating
`default_nettype none
`include "nscs_params.svh"
module nscs_tx_gate (
  input wire logic i_clk,                                   // System clock
  input wire logic i_rstn,                                  // Async reset, active low
  input wire logic i_tx_clk,                                // Transmit clock level
  input wire logic i_gate_en,                               // Gating enabled
  input wire logic [`NSCS_GATE_W-1:0] i_gate,               // Per-group gate, high stops
  output logic [`NSCS_LANES-1:0] o_lane_clk                 // Per-lane transmit clock
);
  logic [`NSCS_LANES-1:0] lane_d;
  logic [`NSCS_LANES-1:0] lane_q;

  // Lane pairs share one gate bit; lanes 1 and 6 always run so their neighbours keep a reference
  genvar g;
  generate
    for (g = 0; g < `NSCS_LANES; g++)
    begin : g_lane
      if (g == `NSCS_KEEP_A || g == `NSCS_KEEP_B)
      begin : g_keep
        always_comb lane_d[g] = i_tx_clk;
      end
      else
      begin : g_gated
        always_comb lane_d[g] = i_tx_clk & ~(i_gate_en & i_gate[g/2]);
      end
    end
  endgenerate

  // Register lane clocks
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      lane_q <= '0;
    else
      lane_q <= lane_d;
  end

  assign o_lane_clk = lane_q;
endmodule : nscs_tx_gate
`default_nettype wire

/* rtl/nscs_top.sv */
// Nibble controller clock selection with AXI4-Lite configuration
//
// Behaviour
// - Each setting has a register bit.
// - Borrow positive read clock from sibling.
// - Borrow negative read clock from sibling.
// - Serial mode samples with master clock, divided.
// - Non-serial mode samples with lane 0 strobe.
// - Positive edge shift 0 or 90, default 0.
// - Negative edge shift 0 or 90, default 0.
// - Optionally invert lane 0 sample clock.
// - Lanes 1 and 6 never gated.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
`include "nscs_params.svh"
module nscs_top (
  input wire logic I_REF_CLK,                               // System clock, 25 MHz
  input wire logic I_RSTN,                                  // Async reset, active low
  input wire logic [`NSCS_ADDR_W-1:0] I_AWADDR,             // Write address
  input wire logic I_AWVALID,                               // Write address valid
  output logic O_AWREADY,                                   // Write address ready
  input wire logic [31:0] I_WDATA,                          // Write data
  input wire logic [3:0] I_WSTRB,                           // Write byte strobes
  input wire logic I_WVALID,                                // Write data valid
  output logic O_WREADY,                                    // Write data ready
  output logic [1:0] O_BRESP,                               // Write response
  output logic O_BVALID,                                    // Write response valid
  input wire logic I_BREADY,                                // Write response ready
  input wire logic [`NSCS_ADDR_W-1:0] I_ARADDR,             // Read address
  input wire logic I_ARVALID,                               // Read address valid
  output logic O_ARREADY,                                   // Read address ready
  output logic [31:0] O_RDATA,                              // Read data
  output logic [1:0] O_RRESP,                               // Read response
  output logic O_RVALID,                                    // Read data valid
  input wire logic I_RREADY,                                // Read data ready
  input wire logic I_PLL_CLK,                               // Phase-locked master clock level
  input wire logic I_REFERENCE_MASTER_CLOCK,                // Reference master clock level
  input wire logic I_LANE0_STROBE,                          // Strobe received on lane0_slice
  input wire logic I_LOCAL_POS_CLK,                         // Local positive-edge read clock
  input wire logic I_LOCAL_NEG_CLK,                         // Local neg_edge_read_clock
  input wire logic I_SIBLING_POS_CLK,                       // Positive read clock from sibling
  input wire logic I_SIBLING_NEG_CLK,                       // Negative read clock from sibling
  input wire logic I_TX_CLK,                                // Transmit clock level
  input wire logic [`NSCS_GATE_W-1:0] I_TRANSMIT_GATE_INPUT, // Fabric transmit gate
  output logic O_POS_TO_SIBLING,                            // Local positive clock to sibling
  output logic O_NEG_TO_SIBLING,                            // Local negative clock to sibling
  output logic O_POS_READ_CLK,                              // Selected positive read clock
  output logic O_NEG_READ_CLK,                              // Selected neg_edge_read_clock
  output logic O_SAMPLE_CLK,                                // Sample clock, lanes 1 and up
  output logic O_SAMPLE_DIV2,                               // Master clock divided by two
  output logic O_LANE0_SAMPLE_CLK,                          // Sample clock for lane0_slice
  output logic O_NIBBLE_RST,                                // Nibble held in reset, high
  output logic [`NSCS_LANES-1:0] O_TX_LANE_CLK              // Per-lane transmit clock
);
  // Bus state
  logic aw_have_d, aw_have_q, w_have_d, w_have_q;
  logic [`NSCS_ADDR_W-1:0] awaddr_d, awaddr_q;
  logic [31:0] wdata_d, wdata_q;
  logic [3:0] wstrb_d, wstrb_q;
  logic awready_d, awready_q, wready_d, wready_q;
  logic bvalid_d, bvalid_q, arready_d, arready_q, rvalid_d, rvalid_q;
  logic [1:0] bresp_d, bresp_q, rresp_d, rresp_q;
  logic [31:0] rdata_d, rdata_q;
  // Register state
  nscs_pkg::nscs_cfg_s cfg_d, cfg_q, act_d, act_q;
  logic nrst_d, nrst_q;
  // Clock path state
  logic pos_d, pos_q, neg_d, neg_q, pos_dly_d, pos_dly_q, neg_dly_d, neg_dly_q;
  logic samp_d, samp_q, lane0_d, lane0_q, mprev_d, mprev_q, div_d, div_q;
  logic fwd_pos_d, fwd_pos_q, fwd_neg_d, fwd_neg_q;
  logic master;

  // AXI4-Lite slave and configuration registers; write data applies only with low byte strobe
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    cfg_d = cfg_q;
    nrst_d = nrst_q;
    if (I_AWVALID && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = I_AWADDR;
    end
    if (I_WVALID && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = I_WDATA;
      wstrb_d = I_WSTRB;
    end
    if (bvalid_q && I_BREADY)
      bvalid_d = 1'b0;
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `NSCS_RESP_OKAY;
      case (awaddr_q)
        `NSCS_OFS_CFG:
        begin
          if (wstrb_q[0])
            cfg_d = nscs_pkg::nscs_cfg_s'(wdata_q[7:0]);
        end
        `NSCS_OFS_CTRL:
        begin
          if (wstrb_q[0])
            nrst_d = wdata_q[0];
        end
        `NSCS_OFS_STATUS: ;
        default: bresp_d = `NSCS_RESP_SLVERR;
      endcase
    end
    if (rvalid_q && I_RREADY)
      rvalid_d = 1'b0;
    if (I_ARVALID && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `NSCS_RESP_OKAY;
      case (I_ARADDR)
        `NSCS_OFS_CFG: rdata_d = {24'h000000, cfg_q};
        `NSCS_OFS_CTRL: rdata_d = {31'h00000000, nrst_q};
        `NSCS_OFS_STATUS: rdata_d = {23'h000000, nrst_q, act_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = `NSCS_RESP_SLVERR;
        end
      endcase
    end
    // Ready drops while a word is held, so one write and one read stand at a time
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `NSCS_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `NSCS_RESP_OKAY;
      rdata_q <= 32'h00000000;
      cfg_q <= `NSCS_CFG_RST;
      nrst_q <= `NSCS_CTRL_RST;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
      nrst_q <= nrst_d;
    end
  end

  // Active settings follow the register only while the nibble is in reset, so no clock glitches in use
  always_comb
  begin
    act_d = act_q;
    if (nrst_q)
      act_d = cfg_q;
  end

  // Clock selection; the 90 degree shift is modelled as one sample of delay on the chosen edge clock
  always_comb
  begin
    master = act_q.src_ref ? I_REFERENCE_MASTER_CLOCK : I_PLL_CLK;
    fwd_pos_d = I_LOCAL_POS_CLK;
    fwd_neg_d = I_LOCAL_NEG_CLK;
    pos_dly_d = act_q.borrow_pos_read_clock ? I_SIBLING_POS_CLK : I_LOCAL_POS_CLK;
    neg_dly_d = act_q.borrow_neg_read_clock ? I_SIBLING_NEG_CLK : I_LOCAL_NEG_CLK;
    pos_d = act_q.pos_shift90 ? pos_dly_q : pos_dly_d;
    neg_d = act_q.neg_shift90 ? neg_dly_q : neg_dly_d;
    mprev_d = master;
    div_d = div_q;
    if (!act_q.serial_mode)
      div_d = 1'b0;
    else if (master && !mprev_q)
      div_d = !div_q;
    samp_d = act_q.serial_mode ? master : I_LANE0_STROBE;
    lane0_d = samp_d ^ act_q.invert_lane0;
    if (nrst_q)
    begin
      pos_d = 1'b0;
      neg_d = 1'b0;
      samp_d = 1'b0;
      lane0_d = 1'b0;
      div_d = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      act_q <= `NSCS_CFG_RST;
      fwd_pos_q <= 1'b0;
      fwd_neg_q <= 1'b0;
      pos_dly_q <= 1'b0;
      neg_dly_q <= 1'b0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      mprev_q <= 1'b0;
      div_q <= 1'b0;
      samp_q <= 1'b0;
      lane0_q <= 1'b0;
    end
    else
    begin
      act_q <= act_d;
      fwd_pos_q <= fwd_pos_d;
      fwd_neg_q <= fwd_neg_d;
      pos_dly_q <= pos_dly_d;
      neg_dly_q <= neg_dly_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      mprev_q <= mprev_d;
      div_q <= div_d;
      samp_q <= samp_d;
      lane0_q <= lane0_d;
    end
  end

  // Transmit gating lives apart since it is per lane
  nscs_tx_gate u_tx_gate (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_tx_clk(I_TX_CLK),
    .i_gate_en(act_q.tx_gate_en),
    .i_gate(I_TRANSMIT_GATE_INPUT),
    .o_lane_clk(O_TX_LANE_CLK)
  );

  // Outputs straight from flip-flops
  assign O_AWREADY = awready_q;
  assign O_WREADY = wready_q;
  assign O_BRESP = bresp_q;
  assign O_BVALID = bvalid_q;
  assign O_ARREADY = arready_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_RVALID = rvalid_q;
  assign O_POS_TO_SIBLING = fwd_pos_q;
  assign O_NEG_TO_SIBLING = fwd_neg_q;
  assign O_POS_READ_CLK = pos_q;
  assign O_NEG_READ_CLK = neg_q;
  assign O_SAMPLE_CLK = samp_q;
  assign O_SAMPLE_DIV2 = div_q;
  assign O_LANE0_SAMPLE_CLK = lane0_q;
  assign O_NIBBLE_RST = nrst_q;
endmodule : nscs_top
`default_nettype wire

/* dv/nscs_chk.sv */
// Concurrent checks on the nibble sample clock select ports
`default_nettype none
`include "nscs_params.svh"
module nscs_chk (
  input wire logic I_REF_CLK, // Clock
  input wire logic I_RSTN, // Reset, active low
  input wire logic I_LOCAL_POS_CLK, // Local positive clock
  input wire logic I_TX_CLK, // Transmit clock
  input wire logic [`NSCS_GATE_W-1:0] I_TRANSMIT_GATE_INPUT, // Fabric gate
  input wire logic O_POS_TO_SIBLING, // Forwarded clock
  input wire logic O_SAMPLE_CLK, // Sample clock
  input wire logic O_SAMPLE_DIV2, // Divided master
  input wire logic O_LANE0_SAMPLE_CLK, // Lane 0 sample clock
  input wire logic O_NIBBLE_RST, // Nibble held
  input wire logic [`NSCS_LANES-1:0] O_TX_LANE_CLK // Lane clocks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] nr_q;
  logic run;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // Nibble reset over two edges, since outputs may lag its release by one
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
    if (!I_RSTN)
      nr_q <= 2'h3;
    else
      nr_q <= {nr_q[0], O_NIBBLE_RST};
  // Running only once the forced-low edges are behind us
  assign run = !O_NIBBLE_RST && nr_q == 2'h0;
  sib_fwd_a: assert property ($past(I_RSTN) |-> O_POS_TO_SIBLING == $past(I_LOCAL_POS_CLK))
    else $error("sibling clock not forwarded");
  lane_keep_a: assert property (
    run |-> {O_TX_LANE_CLK[6], O_TX_LANE_CLK[1]} == {2{$past(I_TX_CLK)}}) else $error("kept lane gated");
  gate_pair_a: assert property (
    O_TX_LANE_CLK[3] == O_TX_LANE_CLK[2] && O_TX_LANE_CLK[5] == O_TX_LANE_CLK[4]) else $error("group split");
  gate_open_a: assert property (
    run && $past(I_TRANSMIT_GATE_INPUT) == 4'h0 |-> O_TX_LANE_CLK == {7{$past(I_TX_CLK)}})
    else $error("lane stopped with gate low");
  gate_stop_a: assert property (run |-> (O_TX_LANE_CLK & ~{7{$past(I_TX_CLK)}}) == 7'h00)
    else $error("lane clock invented");
  quiet_a: assert property (
    O_NIBBLE_RST && nr_q[0] |-> {O_SAMPLE_CLK, O_SAMPLE_DIV2, O_LANE0_SAMPLE_CLK} == 3'h0)
    else $error("clock runs while nibble held");
  div_edge_a: assert property (run && $changed(O_SAMPLE_DIV2) |-> $rose(O_SAMPLE_CLK))
    else $error("divided clock off edge");
  lane0_rel_a: assert property (run |-> $stable(O_LANE0_SAMPLE_CLK ^ O_SAMPLE_CLK))
    else $error("lane 0 polarity drifts");
  cover property (run && $changed(O_SAMPLE_DIV2));
  cover property (run && O_TX_LANE_CLK[0] != O_TX_LANE_CLK[1]);
  cover property (run && O_LANE0_SAMPLE_CLK != O_SAMPLE_CLK);
endmodule : nscs_chk
bind nscs_top nscs_chk nscs_chk_inst (.*);
`default_nettype wire

/* dv/nscs_partner.sv */
// Sibling nibble controller and fabric gate driver
`default_nettype none
module nscs_partner (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Reset, active low
  input wire logic [3:0] i_gate_cmd, // Groups the fabric may stop
  output logic o_sib_pos, // Sibling positive clock
  output logic o_sib_neg, // Sibling negative clock
  output logic [3:0] o_gate // Transmit gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  // Free count for the sibling's own clocks
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_q + 3'h1;
  // Sibling keeps its own clocks and never borrows ours
  assign o_sib_pos = cnt_q[0];
  assign o_sib_neg = cnt_q[2];
  // Gate pulses so both stop and restart are seen
  assign o_gate = i_gate_cmd & {4{cnt_q[1]}};
endmodule : nscs_partner
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the nibble sample clock select block
`default_nettype none
`include "nscs_params.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %0t: got %h want %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ok = `NSCS_RESP_OKAY;
  localparam logic [1:0] err = `NSCS_RESP_SLVERR;
  logic I_REF_CLK = 1'h0, I_RSTN = 1'h0, I_AWVALID = 1'h0, I_WVALID = 1'h0;
  logic I_BREADY = 1'h0, I_ARVALID = 1'h0, I_RREADY = 1'h0;
  logic [3:0] I_AWADDR = 4'h0, I_ARADDR = 4'h0, I_WSTRB = 4'h0, gcmd = 4'h0, wstrb_v = 4'hF;
  logic [31:0] I_WDATA = 32'h0;
  logic [5:0] lv = 6'h00;
  logic [11:0] p1 = 12'h000, p2 = 12'h000;
  wire logic I_PLL_CLK, I_REFERENCE_MASTER_CLOCK, I_LANE0_STROBE, I_LOCAL_POS_CLK, I_LOCAL_NEG_CLK, I_TX_CLK;
  wire logic I_SIBLING_POS_CLK, I_SIBLING_NEG_CLK;
  wire logic [3:0] I_TRANSMIT_GATE_INPUT;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_POS_TO_SIBLING, O_NEG_TO_SIBLING;
  logic O_POS_READ_CLK, O_NEG_READ_CLK, O_SAMPLE_CLK, O_SAMPLE_DIV2, O_LANE0_SAMPLE_CLK, O_NIBBLE_RST;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA;
  logic [6:0] O_TX_LANE_CLK;
  int n_mismatch = 0, cmp_count = 0;
  // Clock-like inputs follow a fixed walk
  assign {I_TX_CLK, I_LOCAL_NEG_CLK, I_LOCAL_POS_CLK, I_LANE0_STROBE, I_REFERENCE_MASTER_CLOCK, I_PLL_CLK} = lv;
  nscs_top nscs_top_inst (.*);
  nscs_partner nscs_partner_inst (.i_clk(I_REF_CLK), .i_rstn(I_RSTN), .i_gate_cmd(gcmd),
    .o_sib_pos(I_SIBLING_POS_CLK), .o_sib_neg(I_SIBLING_NEG_CLK), .o_gate(I_TRANSMIT_GATE_INPUT));
  // Clock
  always #20 I_REF_CLK = ~I_REF_CLK;
  // Walk the inputs and keep what the design sampled at the last two edges
  always @(posedge I_REF_CLK)
  begin
    lv <= lv + 6'h0B;
    p1 <= {I_TRANSMIT_GATE_INPUT, I_SIBLING_NEG_CLK, I_SIBLING_POS_CLK, lv};
    p2 <= p1;
  end
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Write, both channels offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge I_REF_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= wstrb_v;
    I_AWVALID <= 1'h1;
    I_WVALID <= 1'h1;
    I_BREADY <= 1'h1;
    do
    begin
      @(posedge I_REF_CLK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'h0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'h0;
    end
    while (!O_BVALID);
    I_BREADY <= 1'h0;
    `CHK(O_BRESP, er)
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge I_REF_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'h1;
    I_RREADY <= 1'h1;
    do
    begin
      @(posedge I_REF_CLK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'h0;
    end
    while (!O_RVALID);
    I_RREADY <= 1'h0;
    `CHK(O_RDATA, ed)
    `CHK(O_RRESP, er)
  endtask : rd
  // Load settings with the nibble held, then let it run
  task automatic setup(input logic [7:0] v);
    wr(`NSCS_OFS_CTRL, 32'h1, ok);
    wr(`NSCS_OFS_CFG, {24'h0, v}, ok);
    wr(`NSCS_OFS_CTRL, 32'h0, ok);
    repeat (3) @(posedge I_REF_CLK);
  endtask : setup
  // Compare every clock output with the sampled inputs for a stretch
  task automatic chk_clk(input nscs_pkg::nscs_cfg_s c);
    logic [11:0] s;
    logic pd, m1, sm;
    repeat (16)
    begin
      @(posedge I_REF_CLK);
      pd = O_SAMPLE_DIV2;
      #5;
      m1 = c.src_ref ? p1[1] : p1[0];
      sm = c.serial_mode ? m1 : p1[2];
      s = c.pos_shift90 ? p2 : p1;
      `CHK(O_POS_READ_CLK, c.borrow_pos_read_clock ? s[6] : s[3])
      s = c.neg_shift90 ? p2 : p1;
      `CHK(O_NEG_READ_CLK, c.borrow_neg_read_clock ? s[7] : s[4])
      `CHK(O_SAMPLE_CLK, sm)
      `CHK({O_NEG_TO_SIBLING, O_POS_TO_SIBLING}, {p1[4], p1[3]})
      `CHK(O_NIBBLE_RST, 1'h0)
      `CHK(O_LANE0_SAMPLE_CLK, sm ^ c.invert_lane0)
      `CHK(O_SAMPLE_DIV2 ^ pd, c.serial_mode & m1 & ~(c.src_ref ? p2[1] : p2[0]))
      for (int l = 0; l < 7; l++)
      begin
        `CHK(O_TX_LANE_CLK[l], p1[5] & ~(c.tx_gate_en & p1[8 + l / 2] & (l != 1) & (l != 6)))
      end
    end
  endtask : chk_clk
  // Reset values, read-back, read-only and unmapped places, outputs quiet while held
  task automatic t_regs;
    rd(`NSCS_OFS_CFG, {24'h0, `NSCS_CFG_RST}, ok);
    rd(`NSCS_OFS_CTRL, {31'h0, `NSCS_CTRL_RST}, ok);
    rd(`NSCS_OFS_STATUS, 32'h100, ok);
    wr(`NSCS_OFS_CFG, 32'hFF, ok);
    rd(`NSCS_OFS_CFG, 32'hFF, ok);
    // Low byte strobe clear, so the word must be dropped
    wstrb_v = 4'hE;
    wr(`NSCS_OFS_CFG, 32'h0, ok);
    wstrb_v = 4'hF;
    rd(`NSCS_OFS_CFG, 32'hFF, ok);
    wr(`NSCS_OFS_STATUS, 32'h0, ok);
    rd(`NSCS_OFS_STATUS, 32'h1FF, ok);
    wr(4'hC, 32'h1, err);
    rd(4'hC, 32'h0, err);
    `CHK({O_POS_READ_CLK, O_NEG_READ_CLK, O_SAMPLE_CLK, O_SAMPLE_DIV2, O_LANE0_SAMPLE_CLK}, 5'h00)
    `CHK(O_NIBBLE_RST, 1'h1)
  endtask : t_regs
  // A write while running must not reach the active settings
  task automatic t_freeze;
    gcmd <= 4'hF;
    setup(8'h00);
    wr(`NSCS_OFS_CFG, 32'hFF, ok);
    rd(`NSCS_OFS_STATUS, 32'h0, ok);
    chk_clk(8'h00);
  endtask : t_freeze
  // Each mode and gate pattern; slice delays are not modeled, so zero with shifts
  task automatic t_modes;
    logic [11:0] tbl [10] = '{12'h00F, 12'h030, 12'h040, 12'h0C0, 12'h300, 12'h400, 12'h4C0, 12'h80F,
      12'h805, 12'hBFA};
    for (int i = 0; i < 10; i++)
    begin
      gcmd <= tbl[i][3:0];
      setup(tbl[i][11:4]);
      chk_clk(tbl[i][11:4]);
    end
  endtask : t_modes
  // Main sequence
  initial
  begin
    repeat (2) @(posedge I_REF_CLK);
    I_RSTN <= 1'h1;
    t_regs();
    t_freeze();
    t_modes();
    end_sim();
  end
  // Watchdog, well past the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge I_REF_CLK);
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
